// ---- hdl/ioc_regs.svh ----
// Register offsets, field positions and reset values of the pin change block
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// Byte addresses, one aligned word per register
`define IOC_ADR_C_RISE 8'h00
`define IOC_ADR_C_FALL 8'h04
`define IOC_ADR_C_FLAGS 8'h08
`define IOC_ADR_E_RISE 8'h0c
`define IOC_ADR_E_FALL 8'h10
`define IOC_ADR_E_FLAGS 8'h14
`define IOC_ADR_INT_CTRL 8'h18
`define IOC_ADR_EVT_STATUS 8'h1c
`define IOC_ADR_EVT_MASK 8'h20

// Field positions
`define IOC_E_PIN_BIT 3
`define IOC_IE_BIT 3
`define IOC_SUM_BIT 0
`define IOC_EVT_C_BIT 0
`define IOC_EVT_E_BIT 1

// Reset and fill values
`define IOC_BYTE_RST 8'h00
`define IOC_WORD_FILL 24'h000000

`endif

// ---- hdl/ioc_pkg.sv ----
// Types shared by the pin change interrupt block
package ioc_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone answer from the slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Sticky event bits, also the mask layout
  typedef struct packed {
    logic e_edge;
    logic c_edge;
  } evt_t;

endpackage : ioc_pkg

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous port pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 9
) (
  // Clock and control
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Pins in, sampled pins out
  input logic [WIDTH-1:0] pins_async,
  output logic [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  if (WIDTH < 1)
  begin : g_chk
    $error("pin_sync needs at least one pin");
  end

  // First stage feeds only the second, for metastability settling
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else if (ce)
    begin
      stage1_r <= pins_async; // R13
      stage2_r <= stage1_r;
    end
  end

  assign pins_sync = stage2_r;

  sync_delay_a: assert property ( // R13
    @(posedge clk) disable iff (!rst_n)
    ((rst_n && ce) ##1 ce) |=> pins_sync == $past(pins_async, 2))
  else $error("synchronised pin does not follow input after two stages");

endmodule : pin_sync

// ---- hdl/change_flags.sv ----
// Edge detection and sticky change flags for one port
`timescale 1ns/10ps
module change_flags #(
  parameter int WIDTH = 8
) (
  // Clock and control
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Synchronised pins and edge enables
  input logic [WIDTH-1:0] pins,
  input logic [WIDTH-1:0] rise_en,
  input logic [WIDTH-1:0] fall_en,
  // Software write of the flags
  input logic wr_en,
  input logic [WIDTH-1:0] wr_data,
  // Flags and edge seen this cycle
  output logic [WIDTH-1:0] flags,
  output logic set_any
);

  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] rise_vec;
  logic [WIDTH-1:0] fall_vec;
  logic [WIDTH-1:0] set_vec;
  logic [WIDTH-1:0] flags_nxt;

  if (WIDTH < 1 || WIDTH > 8)
  begin : g_chk
    $error("change_flags width must be 1 to 8");
  end

  // Compare with last sample; enables gate each direction
  assign rise_vec = pins & ~prev_r & rise_en; // R1
  assign fall_vec = ~pins & prev_r & fall_en; // R1
  assign set_vec = rise_vec | fall_vec; // R12
  assign set_any = ce && (|set_vec);

  // Edge set wins over a clearing write in the same cycle
  assign flags_nxt = (wr_en ? wr_data : flags_r) | set_vec; // R11

  // Flags hold until written; prev tracks the pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_r <= '0; // R8
      flags_r <= '0; // R8
    end
    else if (ce)
    begin
      prev_r <= pins; // R13
      flags_r <= flags_nxt; // R2
    end
  end

  assign flags = flags_r;

  edge_sets_a: assert property ( // R1
    @(posedge clk) disable iff (!rst_n)
    (ce && (|set_vec)) |=> ((flags & $past(set_vec)) == $past(set_vec)))
  else $error("enabled edge did not set its flag");

  flag_hold_a: assert property ( // R2
    @(posedge clk) disable iff (!rst_n)
    (!wr_en && set_vec == '0) |=> flags == $past(flags))
  else $error("flag changed with no edge and no write");

  set_wins_a: assert property ( // R11
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_en && (|set_vec)) |=> ((flags & $past(set_vec)) == $past(set_vec)))
  else $error("edge lost during a flag write");

  both_edges_a: assert property ( // R12
    @(posedge clk) disable iff (!rst_n)
    (ce && (|((pins ^ prev_r) & rise_en & fall_en)))
      |=> ((flags & $past((pins ^ prev_r) & rise_en & fall_en)) != '0))
  else $error("pin armed for both edges missed a change");

endmodule : change_flags

// ---- hdl/pin_change_irq.sv ----
// Pin change interrupt logic for the third port and pin 3 of the fifth port
//
// What this block does
// R1 - Enabled rising or falling edge sets port C flag
// R2 - Flag set by edge or by writing one, cleared by writing zero
// R3 - Port E rise enable: only bit 3 implemented
// R4 - Port E fall enable: only bit 3 implemented
// R5 - Armed edge sets pin flag and summed flag
// R6 - Port E flag: only bit 3, hardware set
// R7 - Other port E bits read zero, ignore writes
// R8 - All enables and flags reset to zero
// R9 - Summed flag is OR of all flags
// R10 - Interrupt raised when flag set and enable on
// R11 - Edge during clearing write leaves flag set
// R12 - Both enables detect both edge directions
// R13 - Pins synchronised, compared with previous sample
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "ioc_regs.svh"
module pin_change_irq #(
  parameter int C_WIDTH = 8
) (
  // Clock, reset, clock enable
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Wishbone slave
  input ioc_pkg::wb_req_t wb_req,
  output ioc_pkg::wb_rsp_t wb_rsp,
  // Port pins, asynchronous
  input logic [C_WIDTH-1:0] port_c_pin,
  input logic port_e_pin,
  // Flags of the sibling ports A and B, same clock
  input logic sibling_flags_any,
  // Interrupt outputs
  output logic summed_change_flag,
  output logic change_irq,
  output logic irq
);

  if (C_WIDTH < 1 || C_WIDTH > 8)
  begin : g_chk
    $error("port C width must be 1 to 8");
  end

  // Word-aligned address match, low two bits ignored
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction : reg_hit

  // Port C value zero-extended to a byte
  function automatic logic [7:0] c_byte(input logic [C_WIDTH-1:0] v);
    logic [7:0] b;
    b = `IOC_BYTE_RST;
    b[C_WIDTH-1:0] = v;
    c_byte = b;
  endfunction : c_byte

  // Single port E bit placed in its byte, all else zero
  function automatic logic [7:0] e_byte(input logic v);
    logic [7:0] b;
    b = `IOC_BYTE_RST;
    b[`IOC_E_PIN_BIT] = v;
    e_byte = b;
  endfunction : e_byte

  // Control byte: change enable and read-only summed flag, all else zero
  function automatic logic [7:0] ctrl_byte(input logic ie, input logic sum);
    logic [7:0] b;
    b = `IOC_BYTE_RST;
    b[`IOC_IE_BIT] = ie;
    b[`IOC_SUM_BIT] = sum;
    ctrl_byte = b;
  endfunction : ctrl_byte

  // Event bits in their byte; status and mask share the layout
  function automatic logic [7:0] evt_byte(input ioc_pkg::evt_t v);
    logic [7:0] b;
    b = `IOC_BYTE_RST;
    b[`IOC_EVT_C_BIT] = v.c_edge;
    b[`IOC_EVT_E_BIT] = v.e_edge;
    evt_byte = b;
  endfunction : evt_byte

  logic [C_WIDTH-1:0] c_sync;
  logic e_sync;
  logic [C_WIDTH-1:0] c_rise_r;
  logic [C_WIDTH-1:0] c_fall_r;
  logic e_rise_r;
  logic e_fall_r;
  logic ie_r;
  ioc_pkg::evt_t evt_status_r;
  ioc_pkg::evt_t evt_mask_r;
  ioc_pkg::evt_t evt_status_nxt;
  ioc_pkg::wb_rsp_t rsp_r;
  logic [C_WIDTH-1:0] c_flags;
  logic [0:0] e_flags;
  logic c_set;
  logic e_set;

  // Bus decode: one access per request, answered in the next cycle
  wire access = ce && wb_req.cyc && wb_req.stb && !rsp_r.ack;
  wire wr_acc = access && wb_req.we && wb_req.sel[0];
  wire rd_acc = access && !wb_req.we;
  wire hit_c_rise = reg_hit(wb_req.adr, `IOC_ADR_C_RISE);
  wire hit_c_fall = reg_hit(wb_req.adr, `IOC_ADR_C_FALL);
  wire hit_c_flags = reg_hit(wb_req.adr, `IOC_ADR_C_FLAGS);
  wire hit_e_rise = reg_hit(wb_req.adr, `IOC_ADR_E_RISE);
  wire hit_e_fall = reg_hit(wb_req.adr, `IOC_ADR_E_FALL);
  wire hit_e_flags = reg_hit(wb_req.adr, `IOC_ADR_E_FLAGS);
  wire hit_ctrl = reg_hit(wb_req.adr, `IOC_ADR_INT_CTRL);
  wire hit_status = reg_hit(wb_req.adr, `IOC_ADR_EVT_STATUS);
  wire hit_mask = reg_hit(wb_req.adr, `IOC_ADR_EVT_MASK);
  wire hit_any = hit_c_rise || hit_c_fall || hit_c_flags || hit_e_rise || hit_e_fall
    || hit_e_flags || hit_ctrl || hit_status || hit_mask;
  wire [7:0] wr_byte = wb_req.dat[7:0];
  wire e_wr_bit = wb_req.dat[`IOC_E_PIN_BIT]; // R7

  // Pins cross into the clock domain before any edge logic
  pin_sync #(
    .WIDTH(C_WIDTH + 1)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pins_async({port_e_pin, port_c_pin}),
    .pins_sync({e_sync, c_sync})
  );

  // Port C edge detection and flags
  change_flags #(
    .WIDTH(C_WIDTH)
  ) u_c_flags (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pins(c_sync),
    .rise_en(c_rise_r),
    .fall_en(c_fall_r),
    .wr_en(wr_acc && hit_c_flags),
    .wr_data(wr_byte[C_WIDTH-1:0]),
    .flags(c_flags),
    .set_any(c_set)
  );

  // Port E has one implemented pin; its neighbours do not exist
  change_flags #(
    .WIDTH(1)
  ) u_e_flags (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pins(e_sync),
    .rise_en(e_rise_r),
    .fall_en(e_fall_r),
    .wr_en(wr_acc && hit_e_flags),
    .wr_data(e_wr_bit),
    .flags(e_flags),
    .set_any(e_set)
  ); // R6

  // Enable registers; port E keeps only its bit 3
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      c_rise_r <= '0; // R8
      c_fall_r <= '0;
      e_rise_r <= 1'b0;
      e_fall_r <= 1'b0;
      ie_r <= 1'b0;
      evt_mask_r <= '0;
    end
    else if (wr_acc)
    begin
      if (hit_c_rise)
        c_rise_r <= wr_byte[C_WIDTH-1:0];
      if (hit_c_fall)
        c_fall_r <= wr_byte[C_WIDTH-1:0];
      if (hit_e_rise)
        e_rise_r <= e_wr_bit; // R3
      if (hit_e_fall)
        e_fall_r <= e_wr_bit; // R4
      if (hit_ctrl)
        ie_r <= wr_byte[`IOC_IE_BIT];
      if (hit_mask)
      begin
        evt_mask_r.c_edge <= wr_byte[`IOC_EVT_C_BIT];
        evt_mask_r.e_edge <= wr_byte[`IOC_EVT_E_BIT];
      end
    end
  end

  // Sticky events; a new edge beats the clearing read
  wire status_rd = rd_acc && hit_status;
  assign evt_status_nxt = '{e_edge: (evt_status_r.e_edge && !status_rd) || e_set,
    c_edge: (evt_status_r.c_edge && !status_rd) || c_set};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      evt_status_r <= '0;
    else if (ce)
      evt_status_r <= evt_status_nxt;
  end

  // Summed flag covers every port, siblings included
  assign summed_change_flag = (|c_flags) || e_flags[0] || sibling_flags_any; // R9 R5
  assign change_irq = summed_change_flag && ie_r; // R10
  assign irq = |(evt_status_r & evt_mask_r);

  // Read mux; unmapped addresses read zero and ignore writes
  wire [7:0] rd_byte =
    hit_c_rise ? c_byte(c_rise_r) :
    hit_c_fall ? c_byte(c_fall_r) :
    hit_c_flags ? c_byte(c_flags) :
    hit_e_rise ? e_byte(e_rise_r) : // R7
    hit_e_fall ? e_byte(e_fall_r) :
    hit_e_flags ? e_byte(e_flags[0]) :
    hit_ctrl ? ctrl_byte(ie_r, summed_change_flag) :
    hit_status ? evt_byte(evt_status_r) :
    hit_mask ? evt_byte(evt_mask_r) :
    `IOC_BYTE_RST;

  // Ack for one cycle; data captured before any read-clear lands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rsp_r <= '0;
    else if (ce)
    begin
      rsp_r.ack <= access;
      if (rd_acc)
        rsp_r.dat <= {`IOC_WORD_FILL, rd_byte};
    end
  end

  assign wb_rsp = rsp_r;

  ack_single_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wb_rsp.ack |=> !wb_rsp.ack)
  else $error("ack held longer than one cycle");

  e_unimpl_zero_a: assert property ( // R7
    @(posedge clk) disable iff (!rst_n)
    (rd_acc && (hit_e_rise || hit_e_fall || hit_e_flags))
      |=> (wb_rsp.dat & ~{`IOC_WORD_FILL, e_byte(1'b1)}) == '0)
  else $error("unimplemented port E bits read nonzero");

  e_rise_write_a: assert property ( // R3
    @(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_e_rise) |=> e_rise_r == $past(e_wr_bit))
  else $error("port E rise enable did not take bit 3");

  e_fall_write_a: assert property ( // R4
    @(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_e_fall) |=> e_fall_r == $past(e_wr_bit))
  else $error("port E fall enable did not take bit 3");

  e_edge_flag_a: assert property ( // R6
    @(posedge clk) disable iff (!rst_n)
    (e_set && !sibling_flags_any) |=> (e_flags[0] && summed_change_flag))
  else $error("port E edge did not set flag and summed flag");

  summed_or_a: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    (|c_flags) |-> summed_change_flag)
  else $error("summed flag low with a port C flag set");

  irq_raise_a: assert property ( // R10
    @(posedge clk) disable iff (!rst_n)
    (c_set && ie_r && !wr_acc) |=> change_irq)
  else $error("change interrupt not raised after enabled edge");

  reset_clear_a: assert property ( // R8
    @(posedge clk)
    !rst_n |=> (c_rise_r == '0 && c_fall_r == '0 && !e_rise_r && !e_fall_r
      && c_flags == '0 && !e_flags[0] && !wb_rsp.ack))
  else $error("enable or flag not zero after reset");

  ack_answer_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    access |=> wb_rsp.ack)
  else $error("bus request not answered in the next cycle");

  unmapped_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd_acc && !hit_any) |=> wb_rsp.dat == '0)
  else $error("unmapped address read nonzero");

  flag_write_a: assert property ( // R2
    @(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_c_flags && !c_set) |=> c_flags == $past(wr_byte[C_WIDTH-1:0]))
  else $error("port C flag write did not land");

  e_flag_write_a: assert property ( // R6
    @(posedge clk) disable iff (!rst_n)
    (wr_acc && hit_e_flags && !e_set) |=> e_flags[0] == $past(e_wr_bit))
  else $error("port E flag write did not take bit 3");

  summed_c_edge_a: assert property ( // R5
    @(posedge clk) disable iff (!rst_n)
    c_set |=> (summed_change_flag && c_flags != '0))
  else $error("port C edge did not set flag and summed flag");

  status_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (c_set || e_set)
      |=> ((evt_status_r.c_edge || !$past(c_set)) && (evt_status_r.e_edge || !$past(e_set))))
  else $error("edge event lost from status");

  status_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (status_rd && !c_set && !e_set) |=> evt_status_r == '0)
  else $error("status read did not clear events");

endmodule : pin_change_irq

// ---- verif/pin_model.sv ----
// Far-side model: the port pins that feed the block
`timescale 1ns/10ps
module pin_model (
  // Clock
  input wire logic clk,
  // Levels the bench asks for
  input wire logic [7:0] c_req,
  input wire logic e_req,
  // Pins towards the block
  output logic [7:0] port_c_pin,
  output logic port_e_pin
);
  // Pins move on the clock edge after the bench asks, by nonblocking assignment, so the block samples the old level
  initial
  begin
    port_c_pin = 8'h00;
    port_e_pin = 1'b0;
  end
  always @(posedge clk)
  begin
    port_c_pin <= c_req;
    port_e_pin <= e_req;
  end
endmodule : pin_model

// ---- verif/testbench.sv ----
// Register-level tests of the pin change interrupt block
`timescale 1ns/10ps
`include "ioc_regs.svh"
module testbench;
  logic clk;
  logic rst_n;
  logic sib;
  logic [7:0] c_req;
  logic e_req;
  logic [7:0] c_pin;
  logic e_pin;
  logic sum_f;
  logic chg_irq;
  logic irq;
  ioc_pkg::wb_req_t req;
  ioc_pkg::wb_rsp_t rsp;
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  // Block under test and its pins
  pin_change_irq #(.C_WIDTH(8)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_req(req),
    .wb_rsp(rsp), .port_c_pin(c_pin), .port_e_pin(e_pin), .sibling_flags_any(sib),
    .summed_change_flag(sum_f), .change_irq(chg_irq), .irq(irq));
  pin_model pins_u (.clk(clk), .c_req(c_req), .e_req(e_req), .port_c_pin(c_pin),
    .port_e_pin(e_pin));

  task close_out;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  // One classic cycle; ack is sampled at the edge, before the slave updates
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:4'h1, dat:{24'h000000, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask : wb

  task rchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h000000, e}, rd);
  endtask : rchk

  // Pin to flag takes three edges; six leaves margin
  task settle;
    repeat (6) @(posedge clk);
  endtask : settle

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      close_out;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    sib = 1'b0;
    c_req = 8'h00;
    e_req = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rchk(8'(a), 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
    // Only bit 3 of the port E registers holds
    wb(1'b1, `IOC_ADR_E_RISE, 8'hff);
    rchk(`IOC_ADR_E_RISE, 8'h08);
    wb(1'b1, `IOC_ADR_E_FALL, 8'hf7);
    rchk(`IOC_ADR_E_FALL, 8'h00);
    wb(1'b1, `IOC_ADR_E_FALL, 8'h08);
    rchk(`IOC_ADR_E_FALL, 8'h08);
    wb(1'b1, `IOC_ADR_E_FLAGS, 8'hf7);
    rchk(`IOC_ADR_E_FLAGS, 8'h00);
    // Both directions on the port E pin
    e_req <= 1'b1;
    settle;
    rchk(`IOC_ADR_E_FLAGS, 8'h08);
    wb(1'b1, `IOC_ADR_E_FLAGS, 8'h00);
    rchk(`IOC_ADR_E_FLAGS, 8'h00);
    e_req <= 1'b0;
    settle;
    rchk(`IOC_ADR_E_FLAGS, 8'h08);
    rchk(`IOC_ADR_EVT_STATUS, 8'h02);
    rchk(`IOC_ADR_EVT_STATUS, 8'h00);
    wb(1'b1, `IOC_ADR_E_FLAGS, 8'h00);
    $display("test port e done");
    // Port C edges only where enabled
    wb(1'b1, `IOC_ADR_C_RISE, 8'h01);
    wb(1'b1, `IOC_ADR_C_FALL, 8'h80);
    wb(1'b1, `IOC_ADR_EVT_MASK, 8'h01);
    c_req <= 8'h81;
    settle;
    rchk(`IOC_ADR_C_FLAGS, 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    chk("change_irq", 32'h0, {31'h0, chg_irq});
    c_req <= 8'h00;
    settle;
    rchk(`IOC_ADR_C_FLAGS, 8'h81);
    rchk(`IOC_ADR_INT_CTRL, 8'h01);
    wb(1'b1, `IOC_ADR_INT_CTRL, 8'h08);
    chk("change_irq", 32'h1, {31'h0, chg_irq});
    rchk(`IOC_ADR_EVT_STATUS, 8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, `IOC_ADR_C_FLAGS, 8'h80);
    rchk(`IOC_ADR_C_FLAGS, 8'h80);
    wb(1'b1, `IOC_ADR_C_FLAGS, 8'h00);
    chk("summed", 32'h0, {31'h0, sum_f});
    // Edge lands on the edge of a clearing write: three edges after the pin
    c_req <= 8'h81;
    repeat (2) @(posedge clk);
    wb(1'b1, `IOC_ADR_C_FLAGS, 8'h00);
    rchk(`IOC_ADR_C_FLAGS, 8'h01);
    wb(1'b1, `IOC_ADR_C_FLAGS, 8'h00);
    chk("change_irq", 32'h0, {31'h0, chg_irq});
    c_req <= 8'h00;
    settle;
    chk("change_irq", 32'h1, {31'h0, chg_irq});
    wb(1'b1, `IOC_ADR_C_FLAGS, 8'h00);
    $display("test port c done");
    // Sibling ports reach the summed flag
    sib <= 1'b1;
    @(posedge clk);
    chk("summed", 32'h1, {31'h0, sum_f});
    chk("change_irq", 32'h1, {31'h0, chg_irq});
    sib <= 1'b0;
    // Unmapped place and a reset in mid-run
    wb(1'b1, 8'h24, 8'hff);
    rchk(8'h24, 8'h00);
    wb(1'b1, `IOC_ADR_C_RISE, 8'hff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`IOC_ADR_C_RISE, 8'h00);
    rchk(`IOC_ADR_INT_CTRL, 8'h00);
    $display("test misc done");
    close_out;
  end
endmodule : testbench
